// ---- verilog/bbap_params.svh ----
`ifndef BBAP_PARAMS_SVH
`define BBAP_PARAMS_SVH
`define BBAP_UPPER_W 16
`define BBAP_LOWER_W 16
`define BBAP_WORD_LSB 1
`define BBAP_WORD_MSB 3
`define BBAP_LATCH_LSB 4
`define BBAP_WORD_W 3
`define BBAP_BURST_W 4
`define BBAP_DIV_RST 1'b0
`define BBAP_ONE_WORD 3'h1
`define BBAP_ONE_CNT 4'h1
`define BBAP_ZERO_CNT 4'h0
`endif

// ---- verilog/bbap_pkg.sv ----
`default_nettype none
package bbap_pkg;
    typedef enum logic [4:0] {
        BBAP_IDLE = 5'b00001,
        BBAP_ADDR = 5'b00010,
        BBAP_DATA = 5'b00100,
        BBAP_WAIT = 5'b01000,
        BBAP_HOLD = 5'b10000
    } bbap_state_t;
endpackage : bbap_pkg
`default_nettype wire

// ---- verilog/bbap_bus_master.sv ----
// Behaviour
// - Internal processor clock is the double-rate input divided by two.
// - Upper sixteen address lines held valid for the whole burst.
// - Low address then data share the same bidirectional lines.
// - Word address bits increment to the next half-word each burst step.
// - Word address bits equal shared lines 3 to 1 during address cycle.
// - Address latch strobe high in address state, low before data state.
// - Address latch strobe floats during bus hold state.
// - Address status low in address state, high in following data state.
// - Address status held high during reset.
// - Write/read indication presented in each address state.
// - Write/read held in a register through all data states.
// - Data state stretched by wait states until ready is seen and, for reads, the buffer has room.
// - Data enable low in data states; outside drives lines only then.
// - Direction low for reads, high for writes, in address and data states.
`include "bbap_params.svh"
`default_nettype none
module bbap_bus_master
    import bbap_pkg::*;
#(
    parameter int UPPER_W = `BBAP_UPPER_W,
    parameter int LOWER_W = `BBAP_LOWER_W
) (
    input wire logic double_rate_clock_in,
    input wire logic rstn,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [`BBAP_BURST_W-1:0] req_count,
    input wire logic [LOWER_W-1:0] wr_data,
    output logic wr_data_ready,
    // Read data side, two-entry buffer
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [LOWER_W-1:0] rd_data,
    // Hold request from another master
    input wire logic hold_req,
    output logic hold_ack,
    // Bus pins
    output logic [UPPER_W-1:0] upper_address_lines,
    output logic [LOWER_W-1:0] shared_addr_data_lines_out,
    output logic shared_addr_data_lines_oe_n,
    input wire logic [LOWER_W-1:0] shared_addr_data_lines_in,
    output logic [`BBAP_WORD_W-1:0] word_address_bits,
    output logic ale,
    output logic ale_oe_n,
    output logic address_status_n,
    output logic data_enable_n,
    output logic transfer_direction,
    output logic write_read,
    input wire logic ready_n
);
    // ------------------------------------------------------------
    // Clock divider
    // ------------------------------------------------------------
    logic phase;
    always_ff @(posedge double_rate_clock_in or negedge rstn) begin
        if (!rstn) begin
            phase <= `BBAP_DIV_RST;
        end else begin
            phase <= ~phase;
        end
    end
    wire logic step = phase;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [LOWER_W-1:0] din_s1, din_s2;
    logic rdy_s1, rdy_s2, hold_s1, hold_s2;
    always_ff @(posedge double_rate_clock_in or negedge rstn) begin
        if (!rstn) begin
            din_s1 <= '0;
            din_s2 <= '0;
            rdy_s1 <= 1'b1;
            rdy_s2 <= 1'b1;
            hold_s1 <= 1'b0;
            hold_s2 <= 1'b0;
        end else begin
            din_s1 <= shared_addr_data_lines_in;
            din_s2 <= din_s1;
            rdy_s1 <= ready_n;
            rdy_s2 <= rdy_s1;
            hold_s1 <= hold_req;
            hold_s2 <= hold_s1;
        end
    end

    // ------------------------------------------------------------
    // Read buffer
    // ------------------------------------------------------------
    logic [LOWER_W-1:0] buf_mem [2];
    logic buf_wp, buf_rp;
    logic [1:0] buf_cnt;
    logic buf_push, buf_pop;
    wire logic buf_full = (buf_cnt == 2'h2);
    assign rd_valid = (buf_cnt != 2'h0);
    assign rd_data = buf_mem[buf_rp];
    assign buf_pop = rd_valid && rd_ready;
    always_ff @(posedge double_rate_clock_in or negedge rstn) begin
        if (!rstn) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (buf_push) begin
                buf_mem[buf_wp] <= din_s2;
                buf_wp <= ~buf_wp;
            end
            if (buf_pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    bbap_state_t state, next_state;
    logic [`BBAP_BURST_W-1:0] left;
    logic wr_q;
    logic [UPPER_W-1:0] up_q;
    logic [LOWER_W-1:0] lo_q;
    logic [`BBAP_WORD_W-1:0] word_q;
    logic [LOWER_W-1:0] wd_q;

    wire logic ready_seen = !rdy_s2;
    // Ready must be seen; reads must also have buffer room
    wire logic can_xfer = ready_seen && (wr_q || !buf_full);
    wire logic last = (left == `BBAP_ONE_CNT);

    always_comb begin
        next_state = state;
        case (state)
            BBAP_IDLE: begin
                if (hold_s2) begin
                    next_state = BBAP_HOLD;
                end else if (req_valid) begin
                    next_state = BBAP_ADDR;
                end
            end
            BBAP_ADDR: next_state = BBAP_DATA;
            BBAP_DATA, BBAP_WAIT: begin
                if (!can_xfer) begin
                    next_state = BBAP_WAIT;
                end else if (last) begin
                    next_state = hold_s2 ? BBAP_HOLD : BBAP_IDLE;
                end else begin
                    next_state = BBAP_DATA;
                end
            end
            BBAP_HOLD: begin
                if (!hold_s2) begin
                    next_state = BBAP_IDLE;
                end
            end
            default: next_state = BBAP_IDLE;
        endcase
    end

    wire logic in_data = (state == BBAP_DATA) || (state == BBAP_WAIT);
    wire logic xfer = step && in_data && can_xfer;
    assign req_ready = step && (state == BBAP_IDLE) && !hold_s2;
    assign wr_data_ready = xfer && wr_q;
    assign buf_push = xfer && !wr_q;
    assign hold_ack = (state == BBAP_HOLD);

    always_ff @(posedge double_rate_clock_in or negedge rstn) begin
        if (!rstn) begin
            state <= BBAP_IDLE;
        end else if (step) begin
            state <= next_state;
        end
    end

    always_ff @(posedge double_rate_clock_in or negedge rstn) begin
        if (!rstn) begin
            left <= `BBAP_ZERO_CNT;
            wr_q <= 1'b0;
            up_q <= '0;
            lo_q <= '0;
            word_q <= '0;
        end else if (req_valid && req_ready) begin
            left <= (req_count == `BBAP_ZERO_CNT) ? `BBAP_ONE_CNT : req_count;
            wr_q <= req_write;
            up_q <= req_addr[31:LOWER_W];
            lo_q <= req_addr[LOWER_W-1:0];
            word_q <= req_addr[`BBAP_WORD_MSB:`BBAP_WORD_LSB];
        end else if (xfer) begin
            left <= left - `BBAP_ONE_CNT;
            word_q <= word_q + `BBAP_ONE_WORD;
        end
    end

    always_ff @(posedge double_rate_clock_in or negedge rstn) begin
        if (!rstn) begin
            wd_q <= '0;
        end else if (req_valid && req_ready) begin
            wd_q <= wr_data;
        end else if (xfer && wr_q) begin
            wd_q <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    wire logic is_addr = (state == BBAP_ADDR);
    assign upper_address_lines = up_q;
    assign word_address_bits = word_q;
    // Address first, then write data or released for reads
    assign shared_addr_data_lines_out = is_addr ? lo_q : wd_q;
    assign shared_addr_data_lines_oe_n = !(is_addr || (in_data && wr_q));
    assign ale = is_addr && !phase;
    assign ale_oe_n = (state == BBAP_HOLD);
    assign address_status_n = !is_addr;
    assign data_enable_n = !in_data;
    assign write_read = wr_q;
    assign transfer_direction = (is_addr || in_data) ? wr_q : 1'b1;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_as_addr;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        (state == BBAP_ADDR) |-> !address_status_n && data_enable_n;
    endproperty
    a_as_addr: assert property (p_as_addr) else $error("status wrong in address");

    property p_ale_data;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        in_data |-> !ale && address_status_n;
    endproperty
    a_ale_data: assert property (p_ale_data) else $error("strobe in data");

    property p_ale_hold;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        (state == BBAP_HOLD) |-> ale_oe_n && data_enable_n;
    endproperty
    a_ale_hold: assert property (p_ale_hold) else $error("strobe driven in hold");

    property p_mux;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        is_addr |-> shared_addr_data_lines_out[`BBAP_WORD_MSB:`BBAP_WORD_LSB]
            == word_address_bits;
    endproperty
    a_mux: assert property (p_mux) else $error("word bits mismatch");

    property p_wait;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        (step && in_data && !ready_seen) |=> (state == BBAP_WAIT);
    endproperty
    a_wait: assert property (p_wait) else $error("no wait state");

    property p_wr_stable;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        (in_data && $past(in_data)) |-> $stable(write_read);
    endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("write/read changed");

    property p_incr;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        xfer |=> word_address_bits == $past(word_address_bits) + `BBAP_ONE_WORD;
    endproperty
    a_incr: assert property (p_incr) else $error("word address not incremented");

    property p_div;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        step |=> !step ##1 step;
    endproperty
    a_div: assert property (p_div) else $error("divider broken");

    property p_dir;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        in_data |-> transfer_direction == write_read;
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

    property p_seq;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        (step && is_addr) |=> in_data;
    endproperty
    a_seq: assert property (p_seq) else $error("address not followed by data");

    property p_upper_hold;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        in_data |-> $stable(upper_address_lines);
    endproperty
    a_upper_hold: assert property (p_upper_hold) else $error("upper lines moved");

    property p_rd_release;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        (in_data && !write_read) |-> shared_addr_data_lines_oe_n && !data_enable_n;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("lines driven in read");

    property p_wr_addr;
        @(posedge double_rate_clock_in) disable iff (!rstn)
        is_addr |-> transfer_direction == write_read && !shared_addr_data_lines_oe_n;
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("address state drive wrong");
endmodule : bbap_bus_master
`default_nettype wire

// ---- testbench/bbap_mem_model.sv ----
`default_nettype none
module bbap_mem_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic [15:0] upper,
    input wire logic [15:0] ad_out,
    input wire logic [2:0] word,
    input wire logic as_n,
    input wire logic den_n,
    input wire logic wr,
    output logic [15:0] ad_in,
    output logic ready_n,
    output logic wr_seen,
    output logic [31:0] wr_addr,
    output logic [15:0] wr_val
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] base;
    logic [31:0] cur;
    logic [2:0] w0;
    int seed = 75;
    int n;
    // ----------------------------
    // Address capture and read data
    // ----------------------------
    assign cur = {base[31:4], word, 1'b0};
    always @(posedge clk) begin
        if (rstn && !as_n) begin
            base <= {upper, ad_out[15:4], 4'h0};
        end
        // Released lines toggle so a stale value never passes
        if (!rstn) begin
            ad_in <= 16'h5A5A;
        end else begin
            ad_in <= (!den_n && !wr) ? cur[15:0] ^ cur[31:16] ^ 16'hA5C3 : ~ad_in;
        end
    end
    // Two-cycle ready pulse per word: exactly one of its edges is a bus step
    initial begin
        ready_n = 1'b1;
        wr_seen = 1'b0;
        forever begin
            @(posedge clk);
            if (den_n === 1'b0) begin
                ready_n <= 1'b0;
                wr_seen <= wr;
                wr_addr <= cur;
                wr_val <= ad_out;
                w0 = word;
                @(posedge clk);
                wr_seen <= 1'b0;
                @(posedge clk);
                ready_n <= 1'b1;
                for (n = 0; n < 14 && word === w0 && den_n === 1'b0; n++) @(posedge clk);
                repeat (slow ? 1 + ($random(seed) & 3) : 1) @(posedge clk);
            end
        end
    end
endmodule : bbap_mem_model
`default_nettype wire

// ---- testbench/tb_burst_bus_address_phase.sv ----
`default_nettype none
module tb_burst_bus_address_phase
    import bbap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, req_valid, req_ready, req_write, wr_data_ready, rd_valid, rd_ready;
    logic hold_req, hold_ack, oe_n, ale, ale_oe_n, as_n, den_n, dir, wrd, ready_n;
    logic slow, wr_seen, cur_wr;
    logic as_q = 1'b1;
    logic [31:0] req_addr, wr_addr, cur_addr;
    logic [15:0] wr_data, rd_data, upper, ad_out, ad_in, m_ad, wr_val;
    logic [3:0] req_count;
    logic [2:0] word;
    logic [15:0] wd[16];
    logic [47:0] wq[$];
    logic [15:0] rq[$];
    logic [3:0] cnts[12] = '{4'h1, 4'h0, 4'h8, 4'h8, 4'h3, 4'h5, 4'h2, 4'h7, 4'h6, 4'h4,
                             4'h8, 4'h1};
    int errors = 0;
    int check_count = 0;
    int seed = 75;
    int wi = 0;
    int t;
    // ----------------------------
    // Design, far side and shared lines
    // ----------------------------
    bbap_bus_master bbap_bus_master_inst (.double_rate_clock_in(clk), .rstn(rstn),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_write(req_write), .req_count(req_count), .wr_data(wr_data),
        .wr_data_ready(wr_data_ready), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .hold_req(hold_req), .hold_ack(hold_ack),
        .upper_address_lines(upper), .shared_addr_data_lines_out(ad_out),
        .shared_addr_data_lines_oe_n(oe_n), .shared_addr_data_lines_in(ad_in),
        .word_address_bits(word), .ale(ale), .ale_oe_n(ale_oe_n),
        .address_status_n(as_n), .data_enable_n(den_n), .transfer_direction(dir),
        .write_read(wrd), .ready_n(ready_n));
    bbap_mem_model bbap_mem_model_inst (.clk(clk), .rstn(rstn), .slow(slow), .upper(upper),
        .ad_out(ad_out), .word(word), .as_n(as_n), .den_n(den_n), .wr(wrd), .ad_in(m_ad),
        .ready_n(ready_n), .wr_seen(wr_seen), .wr_addr(wr_addr), .wr_val(wr_val));
    assign ad_in = !oe_n ? ad_out : m_ad;
    // First word at the take, later words after each consume pulse
    assign wr_data = req_valid ? wd[0] : wd[wi[3:0]];
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic xfer(input logic w, input logic [3:0] cnt, input logic [31:0] a);
        int k;
        logic [31:0] e;
        @(posedge clk);
        for (k = 0; k < (cnt == 4'h0 ? 1 : int'(cnt)); k++) begin
            e = {a[31:4], a[3:1] + 3'(k), 1'b0};
            wd[k] = 16'($random(seed));
            if (w) wq.push_back({e, wd[k]});
            else rq.push_back(e[15:0] ^ e[31:16] ^ 16'hA5C3);
        end
        cur_addr <= a;
        cur_wr <= w;
        req_valid <= 1'b1;
        req_write <= w;
        req_count <= cnt;
        req_addr <= a;
        // Ready is looked at mid-cycle; the following edge takes the request
        @(negedge clk);
        for (k = 0; k < 300 && req_ready !== 1'b1; k++) @(negedge clk);
        if (k == 300) errors++;
        @(posedge clk);
        req_valid <= 1'b0;
        for (k = 0; k < 900 && (wq.size() || rq.size() || den_n !== 1'b1); k++) @(posedge clk);
        if (k == 900) errors++;
    endtask : xfer
    // ----------------------------
    // Watcher of pins and results
    // ----------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            check({as_n, den_n, dir}, 3'b111);
        end else begin
            if (!as_n) begin
                check({ad_out, word}, {cur_addr[15:0], cur_addr[3:1]});
                check({upper, wrd, dir, den_n}, {cur_addr[31:16], cur_wr, cur_wr, 1'b1});
                // Strobe high only in the first half of the address state
                check({ale, ale_oe_n, oe_n}, {as_q, 2'b00});
            end
            if (!den_n) begin
                check({upper, wrd, dir, ale}, {cur_addr[31:16], cur_wr, cur_wr, 1'b0});
                check(oe_n, !cur_wr);
            end
            if (hold_ack) check({ale_oe_n, as_n, req_ready}, 3'b110);
            if (wr_seen) check({wr_addr, wr_val}, wq.size() ? wq.pop_front() : 'x);
            if (rd_valid && rd_ready) check(rd_data, rq.size() ? rq.pop_front() : 'x);
        end
        if (req_valid && req_ready) begin
            wi <= 1;
        end else if (wr_data_ready) begin
            wi <= wi + 1;
        end
        as_q <= as_n;
        rd_ready <= slow ? 1'($random(seed)) : 1'b1;
    end
    initial begin
        #300000;
        errors++;
        summarize();
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_count = 4'h0;
        req_addr = 32'h0;
        hold_req = 1'b0;
        slow = 1'b0;
        cur_wr = 1'b0;
        cur_addr = 32'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        for (t = 0; t < 12; t++) begin
            slow <= t[1];
            xfer(t[0], cnts[t], 32'($random(seed)) & 32'hFFFF_FFFE);
            $display("Test %0d done, errors %0d", t, errors);
        end
        hold_req <= 1'b1;
        repeat (12) @(posedge clk);
        check(hold_ack, 1'b1);
        fork
            begin
                repeat (30) @(posedge clk);
                hold_req <= 1'b0;
            end
        join_none
        xfer(1'b0, 4'h8, 32'hABCD_FFFA);
        $display("Test hold done, errors %0d", errors);
        summarize();
    end
endmodule : tb_burst_bus_address_phase
`default_nettype wire
